// *** sawt_pkg.sv ***
// constants, field layout and decode helpers for the sram wait timing block
package sawt_pkg;

    // ------------------------------------------------------------------
    // wait control word layout
    // ------------------------------------------------------------------
    localparam int unsigned WW_LSB   = 16;   // write_wait_count [18:16]
    localparam int unsigned SW_LSB   = 11;   // setup delay [12:11]
    localparam int unsigned WR_LSB   = 7;    // access wait [10:7]
    localparam int unsigned WM_POS   = 6;    // external_wait_mask
    localparam int unsigned HW_LSB   = 0;    // hold delay [1:0]
    localparam int unsigned RSV_LSB  = 2;    // reserved [5:2]

    localparam logic [31:0] CFG_RW_MASK = 32'h0007_1fc3;
    localparam logic [31:0] CFG_RESET   = 32'h0000_0540;
    localparam logic [3:0]  WR_RESET    = 4'ha;

    // counter width: longest phase is 2*24+2 clocks
    localparam int unsigned CNT_W = 6;

    // ------------------------------------------------------------------
    // state encoding, gray along idle-setup-strobe-hold
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_SETUP  = 3'h1,
        ST_STROBE = 3'h3,
        ST_HOLD   = 3'h2,
        ST_EWAIT  = 3'h7
    } sawt_state_t;

    // access wait code to bus cycles; prohibited codes clamp to 24
    function automatic logic [4:0] wait_decode(input logic [3:0] code);
        logic [4:0] res;
        res = 5'h18;
        unique case (code)
            4'h0, 4'h1, 4'h2, 4'h3,
            4'h4, 4'h5, 4'h6: res = {1'b0, code};
            4'h7:             res = 5'h08;
            4'h8:             res = 5'h0a;
            4'h9:             res = 5'h0c;
            4'ha:             res = 5'h0e;
            4'hb:             res = 5'h12;
            default:          res = 5'h18;
        endcase
        return res;
    endfunction : wait_decode

    // effective wait for an access, write field overriding when nonzero
    function automatic logic [4:0] access_wait(input logic       write,
                                               input logic [3:0] wr,
                                               input logic [2:0] ww);
        logic [4:0] res;
        res = wait_decode(wr);
        if (write && (ww != 3'h0))
        begin
            res = {2'h0, ww - 3'h1};
        end
        return res;
    endfunction : access_wait

endpackage : sawt_pkg

// *** sawt_cnt_if.sv ***
// carrier between the access sequencer and its phase counter
`timescale 1ns/1ns
interface sawt_cnt_if #(parameter int unsigned CNT_W = 6);
    logic             load;
    logic [CNT_W-1:0] load_val;
    logic             expired;

    modport ctl (output load, output load_val, input expired);
    modport cnt (input load, input load_val, output expired);
endinterface : sawt_cnt_if

// *** sawt_phase_cnt.sv ***
// down counter that times each phase of an access
`timescale 1ns/1ns
module sawt_phase_cnt #(
    parameter int unsigned CNT_W = 6
) (
    input  wire logic clock_i,
    input  wire logic srst_i,
    sawt_cnt_if.cnt   cnt_if
);

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;

    // ------------------------------------------------------------------
    // count down to zero and hold there
    // ------------------------------------------------------------------
    always_comb
    begin
        cnt_next = cnt_reg;
        if (cnt_if.load)
        begin
            cnt_next = cnt_if.load_val;
        end
        else if (cnt_reg != '0)
        begin
            cnt_next = cnt_reg - CNT_W'(1);
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            cnt_reg <= '0;
        end
        else
        begin
            cnt_reg <= cnt_next;
        end
    end

    // a loaded value n expires n+1 cycles later
    assign cnt_if.expired = (cnt_reg == '0);

endmodule : sawt_phase_cnt

// *** sawt_access_ctrl.sv ***
// access sequencer for one normal-space sram chip-select area
`timescale 1ns/1ns
module sawt_access_ctrl #(
    parameter int unsigned ADDR_W = 26
) (
    input  wire logic              clock_i,
    input  wire logic              srst_i,
    input  wire logic              cfg_we_i,
    input  wire logic [31:0]       cfg_wdata_i,
    output logic      [31:0]       cfg_rdata_o,
    input  wire logic              acc_req_i,
    input  wire logic              acc_write_i,
    input  wire logic [ADDR_W-1:0] acc_addr_i,
    output logic                   busy_o,
    output logic                   done_o,
    input  wire logic              ext_wait_i,
    output logic [ADDR_W-1:0]      addr_o,
    output logic                   area_chip_select_n_o,
    output logic                   rd_n_o,
    output logic                   we_n_o
);

    localparam int unsigned CW = sawt_pkg::CNT_W;

    // ------------------------------------------------------------------
    // wait control word
    // ------------------------------------------------------------------
    logic [31:0] cfg_reg;
    logic [31:0] cfg_next;
    logic [3:0]  wr_fld;
    logic [2:0]  ww_fld;
    logic [1:0]  sw_fld;
    logic [1:0]  hw_fld;
    logic        wm_fld;

    // writable bits only; reserved bits stay zero
    always_comb
    begin
        cfg_next = cfg_reg;
        if (cfg_we_i)
        begin
            cfg_next = cfg_wdata_i & sawt_pkg::CFG_RW_MASK;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            cfg_reg <= sawt_pkg::CFG_RESET;
        end
        else
        begin
            cfg_reg <= cfg_next;
        end
    end

    assign wr_fld = cfg_reg[sawt_pkg::WR_LSB +: 4];
    assign ww_fld = cfg_reg[sawt_pkg::WW_LSB +: 3];
    assign sw_fld = cfg_reg[sawt_pkg::SW_LSB +: 2];
    assign hw_fld = cfg_reg[sawt_pkg::HW_LSB +: 2];
    assign wm_fld = cfg_reg[sawt_pkg::WM_POS];
    assign cfg_rdata_o = cfg_reg;

    // ------------------------------------------------------------------
    // access sequencer
    // ------------------------------------------------------------------
    sawt_cnt_if #(.CNT_W(CW)) cnt_if ();

    sawt_phase_cnt #(.CNT_W(CW)) u_cnt (
        .clock_i (clock_i),
        .srst_i  (srst_i),
        .cnt_if  (cnt_if)
    );

    sawt_pkg::sawt_state_t state_reg, state_next;
    logic              wr_reg, wr_next;
    logic              mask_reg, mask_next;
    logic [4:0]        wait_reg, wait_next;
    logic [1:0]        hold_reg, hold_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic              cs_n_reg, cs_n_next;
    logic              rd_n_reg, rd_n_next;
    logic              we_n_reg, we_n_next;
    logic              busy_reg, busy_next;
    logic              done_reg, done_next;
    logic              stb_on;

    // settings are snapshotted at the take so a mid-access write is safe
    always_comb
    begin
        state_next       = state_reg;
        wr_next          = wr_reg;
        mask_next        = mask_reg;
        wait_next        = wait_reg;
        hold_next        = hold_reg;
        addr_next        = addr_reg;
        done_next        = 1'b0;
        cnt_if.load      = 1'b0;
        cnt_if.load_val  = '0;
        unique case (state_reg)
            sawt_pkg::ST_IDLE:
            begin
                if (acc_req_i)
                begin
                    wr_next    = acc_write_i;
                    mask_next  = wm_fld;
                    wait_next  = sawt_pkg::access_wait(acc_write_i, wr_fld,
                                                       ww_fld);
                    hold_next  = hw_fld;
                    addr_next  = acc_addr_i;
                    cnt_if.load     = 1'b1;
                    cnt_if.load_val = {3'h0, sw_fld, 1'b0};
                    state_next = sawt_pkg::ST_SETUP;
                end
            end
            sawt_pkg::ST_SETUP:
            begin
                if (cnt_if.expired)
                begin
                    // one base cycle plus the waits, in half cycles
                    cnt_if.load     = 1'b1;
                    cnt_if.load_val = {wait_reg, 1'b1};
                    state_next = sawt_pkg::ST_STROBE;
                end
            end
            sawt_pkg::ST_STROBE:
            begin
                if (cnt_if.expired)
                begin
                    // wait sampled even after zero waits
                    if (!mask_reg && ext_wait_i)
                    begin
                        state_next = sawt_pkg::ST_EWAIT;
                    end
                    else
                    begin
                        cnt_if.load     = 1'b1;
                        cnt_if.load_val = {3'h0, hold_reg, 1'b0};
                        state_next = sawt_pkg::ST_HOLD;
                    end
                end
            end
            sawt_pkg::ST_EWAIT:
            begin
                if (!ext_wait_i)
                begin
                    cnt_if.load     = 1'b1;
                    cnt_if.load_val = {3'h0, hold_reg, 1'b0};
                    state_next = sawt_pkg::ST_HOLD;
                end
            end
            sawt_pkg::ST_HOLD:
            begin
                if (cnt_if.expired)
                begin
                    done_next  = 1'b1;
                    state_next = sawt_pkg::ST_IDLE;
                end
            end
            default:
            begin
                state_next = sawt_pkg::ST_IDLE;
            end
        endcase
    end

    // pins follow the next state so they leave a flip-flop directly
    always_comb
    begin
        stb_on    = (state_next == sawt_pkg::ST_STROBE) ||
                    (state_next == sawt_pkg::ST_EWAIT);
        busy_next = (state_next != sawt_pkg::ST_IDLE);
        cs_n_next = !busy_next;
        rd_n_next = !(stb_on && !wr_next);
        we_n_next = !(stb_on && wr_next);
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            state_reg <= sawt_pkg::ST_IDLE;
            wr_reg    <= 1'b0;
            mask_reg  <= 1'b1;
            wait_reg  <= '0;
            hold_reg  <= '0;
            addr_reg  <= '0;
            cs_n_reg  <= 1'b1;
            rd_n_reg  <= 1'b1;
            we_n_reg  <= 1'b1;
            busy_reg  <= 1'b0;
            done_reg  <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            wr_reg    <= wr_next;
            mask_reg  <= mask_next;
            wait_reg  <= wait_next;
            hold_reg  <= hold_next;
            addr_reg  <= addr_next;
            cs_n_reg  <= cs_n_next;
            rd_n_reg  <= rd_n_next;
            we_n_reg  <= we_n_next;
            busy_reg  <= busy_next;
            done_reg  <= done_next;
        end
    end

    assign addr_o               = addr_reg;
    assign area_chip_select_n_o = cs_n_reg;
    assign rd_n_o               = rd_n_reg;
    assign we_n_o               = we_n_reg;
    assign busy_o               = busy_reg;
    assign done_o               = done_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    logic       stb_n;
    logic [6:0] stb_len_reg;
    logic [6:0] ph_len_reg;
    logic [1:0] sw_lat_reg;

    assign stb_n = rd_n_reg & we_n_reg;

    // helpers: strobe width and strobe-off width inside a select
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            stb_len_reg <= '0;
            ph_len_reg  <= '0;
            sw_lat_reg  <= '0;
        end
        else
        begin
            stb_len_reg <= stb_n ? 7'h00 : stb_len_reg + 7'h01;
            ph_len_reg  <= (cs_n_reg || !stb_n) ? 7'h00 : ph_len_reg + 7'h01;
            if (state_reg == sawt_pkg::ST_IDLE && acc_req_i)
            begin
                sw_lat_reg <= sw_fld;
            end
        end
    end

    property p_wait_rst;
        @(posedge clock_i) $past(srst_i) && !srst_i |->
            cfg_rdata_o[sawt_pkg::WR_LSB +: 4] == 4'ha &&
            cfg_rdata_o[sawt_pkg::WM_POS] == 1'b1;
    endproperty
    a_wait_rst: assert property (p_wait_rst)
        else $error("wait fields wrong after reset");

    // own table, so a slip in the shared decode cannot hide itself
    localparam logic [4:0] WAIT_TAB [16] = '{
        5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h08,
        5'h0a, 5'h0c, 5'h0e, 5'h12, 5'h18, 5'h18, 5'h18, 5'h18
    };

    property p_read_wait;
        @(posedge clock_i) disable iff (srst_i)
            $rose(busy_reg) && (!wr_reg || $past(ww_fld) == 3'h0) |->
            wait_reg == WAIT_TAB[$past(wr_fld)];
    endproperty
    a_read_wait: assert property (p_read_wait)
        else $error("read wait count mis-decoded");

    property p_write_wait;
        @(posedge clock_i) disable iff (srst_i)
            $rose(busy_reg) && wr_reg && $past(ww_fld) != 3'h0 |->
            int'(wait_reg) == int'($past(ww_fld)) - 1;
    endproperty
    a_write_wait: assert property (p_write_wait)
        else $error("write wait override wrong");

    property p_masked;
        @(posedge clock_i) disable iff (srst_i)
            $rose(stb_n) && !cs_n_reg && mask_reg |->
            int'(stb_len_reg) == 2 * int'(wait_reg) + 2;
    endproperty
    a_masked: assert property (p_masked)
        else $error("masked strobe width wrong");

    property p_zero_wait;
        @(posedge clock_i) disable iff (srst_i)
            state_reg == sawt_pkg::ST_STROBE && cnt_if.expired &&
            !mask_reg && ext_wait_i |=>
            !stb_n ##1 (stb_n == !$past(ext_wait_i));
    endproperty
    a_zero_wait: assert property (p_zero_wait)
        else $error("external wait did not stretch strobe");

    property p_rsv;
        @(posedge clock_i) disable iff (srst_i)
            cfg_rdata_o[sawt_pkg::RSV_LSB +: 4] == 4'h0;
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved bits not zero");

    property p_hold;
        @(posedge clock_i) disable iff (srst_i)
            $rose(cs_n_reg) |->
            int'(ph_len_reg) == 2 * int'(hold_reg) + 1 && done_reg;
    endproperty
    a_hold: assert property (p_hold)
        else $error("hold delay wrong");

    property p_setup;
        @(posedge clock_i) disable iff (srst_i)
            $fell(stb_n) |->
            int'(ph_len_reg) == 2 * int'(sw_lat_reg) + 1;
    endproperty
    a_setup: assert property (p_setup)
        else $error("setup delay wrong");

    property p_ewait_hold;
        @(posedge clock_i) disable iff (srst_i)
            state_reg == sawt_pkg::ST_EWAIT && ext_wait_i |=> !stb_n;
    endproperty
    a_ewait_hold: assert property (p_ewait_hold)
        else $error("strobe released under external wait");

    property p_ewait_end;
        @(posedge clock_i) disable iff (srst_i)
            state_reg == sawt_pkg::ST_EWAIT && !ext_wait_i |=>
            stb_n ##1 !cs_n_reg || done_reg;
    endproperty
    a_ewait_end: assert property (p_ewait_end)
        else $error("strobe not released after external wait");

    c_read:  cover property (@(posedge clock_i) $rose(busy_reg) && !wr_reg);
    c_write: cover property (@(posedge clock_i) $rose(busy_reg) && wr_reg);
    c_ewait: cover property (@(posedge clock_i)
                             state_reg == sawt_pkg::ST_EWAIT);
    c_b2b:   cover property (@(posedge clock_i) done_reg ##1 $fell(cs_n_reg));

endmodule : sawt_access_ctrl

// *** sawt_sram_model.sv ***
// behavioural external memory that may stretch strobes with its wait line
`timescale 1ns/1ns
module sawt_sram_model (
    input  wire logic       clock_i,
    input  wire logic       srst_i,
    input  wire logic       area_chip_select_n_i,
    input  wire logic       rd_n_i,
    input  wire logic       we_n_i,
    input  wire logic [7:0] wait_len_i,
    output logic            ext_wait_o
);
    logic       strobe;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;

    // ------------------------------------------------------------------
    // strobe length counter
    // ------------------------------------------------------------------
    // counts strobe cycles already seen, cleared between strobes
    always_comb
    begin
        strobe   = !area_chip_select_n_i && (!rd_n_i || !we_n_i);
        cnt_next = 8'h00;
        if (strobe && (cnt_reg != 8'hff))
        begin
            cnt_next = cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            cnt_reg <= 8'h00;
        end
        else
        begin
            cnt_reg <= cnt_next;
        end
    end

    // wait asked for the first wait_len strobe cycles only; outside a
    // strobe the line is pulled to its inactive level
    assign ext_wait_o = strobe && (cnt_reg < wait_len_i);
endmodule : sawt_sram_model

// *** sawt_tb_top.sv ***
// self-checking testbench for the sram wait timing sequencer
`timescale 1ns/1ns
module sawt_tb_top;
    logic        clock_i;
    logic        srst_i;
    logic        cfg_we_i;
    logic [31:0] cfg_wdata_i;
    logic [31:0] cfg_rdata_o;
    logic        acc_req_i;
    logic        acc_write_i;
    logic [25:0] acc_addr_i;
    logic        busy_o;
    logic        done_o;
    logic        ext_wait_i;
    logic [25:0] addr_o;
    logic        area_chip_select_n_o;
    logic        rd_n_o;
    logic        we_n_o;
    logic [7:0]  wait_len;
    int          n_fail;
    int          n_checks;
    // prohibited codes run as the longest wait
    int          wtab[16] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18,
                              24, 24, 24, 24};
    // external wait cases: write, ww, wr, mask, wait length, strobe length
    int          ew_w[4]  = '{0, 0, 0, 1};
    int          ew_ww[4] = '{0, 0, 0, 1};
    int          ew_wr[4] = '{0, 0, 3, 0};
    int          ew_wm[4] = '{0, 1, 0, 0};
    int          ew_l[4]  = '{5, 5, 3, 9};
    int          ew_t[4]  = '{6, 2, 8, 10};

    sawt_access_ctrl dut (
        .clock_i              (clock_i),
        .srst_i               (srst_i),
        .cfg_we_i             (cfg_we_i),
        .cfg_wdata_i          (cfg_wdata_i),
        .cfg_rdata_o          (cfg_rdata_o),
        .acc_req_i            (acc_req_i),
        .acc_write_i          (acc_write_i),
        .acc_addr_i           (acc_addr_i),
        .busy_o               (busy_o),
        .done_o               (done_o),
        .ext_wait_i           (ext_wait_i),
        .addr_o               (addr_o),
        .area_chip_select_n_o (area_chip_select_n_o),
        .rd_n_o               (rd_n_o),
        .we_n_o               (we_n_o)
    );

    sawt_sram_model mem (
        .clock_i              (clock_i),
        .srst_i               (srst_i),
        .area_chip_select_n_i (area_chip_select_n_o),
        .rd_n_i               (rd_n_o),
        .we_n_i               (we_n_o),
        .wait_len_i           (wait_len),
        .ext_wait_o           (ext_wait_i)
    );

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
        begin
            $display("All tests passed");
        end
        else
        begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    // field packing; reserved places always zero from software
    function automatic logic [31:0] mk(input int ww, input int sw,
                                       input int wr, input int wm,
                                       input int hw);
        return {13'h0000, 3'(ww), 3'h0, 2'(sw), 4'(wr), 1'(wm), 4'h0,
                2'(hw)};
    endfunction : mk

    // config word write, result readable after the taking edge
    task automatic cfg_write(input logic [31:0] d);
        @(posedge clock_i);
        cfg_we_i    <= 1'b1;
        cfg_wdata_i <= d;
        @(posedge clock_i);
        cfg_we_i    <= 1'b0;
        @(negedge clock_i);
    endtask : cfg_write

    // one access; phases measured on the pins at settled negedges
    task automatic access(input logic wr, input int s, input int t,
                          input int h, input int l);
        int   ncs;
        int   nst;
        int   nset;
        int   nbad;
        int   nbusy;
        int   k;
        logic fin;
        ncs   = 0;
        nst   = 0;
        nset  = 0;
        nbad  = 0;
        nbusy = 0;
        fin   = 1'b0;
        @(posedge clock_i);
        wait_len    <= 8'(l);
        acc_req_i   <= 1'b1;
        acc_write_i <= wr;
        acc_addr_i  <= acc_addr_i + 26'h123457;
        @(posedge clock_i);
        acc_req_i   <= 1'b0;
        for (k = 0; k < 400 && !fin; k++)
        begin
            @(negedge clock_i);
            if (area_chip_select_n_o === 1'b0)
                ncs++;
            if ((wr ? we_n_o : rd_n_o) === 1'b0)
                nst++;
            else if (area_chip_select_n_o === 1'b0 && nst == 0)
                nset++;
            if ((wr ? rd_n_o : we_n_o) !== 1'b1)
                nbad++;
            if (busy_o === 1'b1)
                nbusy++;
            fin = (done_o === 1'b1);
        end
        check(32'(fin), 32'h1);
        check(32'(nset), 32'(s));
        check(32'(nst), 32'(t));
        check(32'(ncs - nset - nst), 32'(h));
        check(32'(nbad), 32'h0);
        check(32'(nbusy), 32'(ncs));
        check({6'h00, addr_o}, {6'h00, acc_addr_i});
    endtask : access

    // ------------------------------------------------------------------
    // clock, reset, watchdog
    // ------------------------------------------------------------------
    initial
    begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    // whole run is about a thousand cycles; this leaves wide margin
    initial
    begin
        repeat (20000) @(posedge clock_i);
        n_fail++;
        end_of_test();
    end

    // ------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------
    initial
    begin
        n_fail      = 0;
        n_checks    = 0;
        srst_i      = 1'b1;
        cfg_we_i    = 1'b0;
        cfg_wdata_i = 32'h0000_0000;
        acc_req_i   = 1'b0;
        acc_write_i = 1'b0;
        acc_addr_i  = 26'h0000000;
        wait_len    = 8'h00;
        repeat (10) @(posedge clock_i);
        srst_i <= 1'b0;
        @(negedge clock_i);
        check(cfg_rdata_o, 32'h0000_0540);
        // deliberate all-ones write: reserved places must stay zero
        cfg_write(32'hffff_ffff);
        check(cfg_rdata_o, 32'h0007_1fc3);
        cfg_write(mk(0, 0, 0, 0, 0));
        check(cfg_rdata_o, 32'h0000_0000);
        // every access wait code on reads, prohibited ones included
        for (int i = 0; i < 16; i++)
        begin
            cfg_write(mk(0, 0, i, 1, 0));
            access(1'b0, 1, 2 * (wtab[i] + 1), 1, 0);
        end
        // write field overrides only writes, long access wait behind it
        for (int i = 0; i < 8; i++)
        begin
            cfg_write(mk(i, 0, 12, 1, 0));
            access(1'b1, 1, (i == 0) ? 50 : 2 * i, 1, 0);
        end
        access(1'b0, 1, 50, 1, 0);
        // every setup and hold code, reads and writes mixed
        for (int i = 0; i < 16; i++)
        begin
            cfg_write(mk(0, i / 4, 1, 1, i % 4));
            access(1'(i), 2 * (i / 4) + 1, 4,
                   2 * (i % 4) + 1, 0);
        end
        // external wait honoured, ignored, shorter than programmed
        for (int i = 0; i < 4; i++)
        begin
            cfg_write(mk(ew_ww[i], 0, ew_wr[i], ew_wm[i], 0));
            access(1'(ew_w[i]), 1, ew_t[i], 1, ew_l[i]);
        end
        end_of_test();
    end
endmodule : sawt_tb_top
